// *** common/saf_defines.svh ***
/*
 * Constants of the receive serial address filter: reset values, field
 * positions and bus codes. Assumes a 10-bit maximum character width.
 */
`ifndef SAF_DEFINES_SVH
`define SAF_DEFINES_SVH

// Accept-all multicast value, 10-bit and 8-bit forms
`define SAF_ADDR_RESET_10 10'h3ff
`define SAF_ADDR_RESET_8 10'h0ff
// Discard policy codes
`define SAF_POLICY_KEEP 2'h0
`define SAF_POLICY_DROP_ADDR 2'h3
// Register access direction on the violation line
`define SAF_DIR_WRITE 1'h0
// Mode on the special/data line
`define SAF_MODE_UNICAST 1'h1
// Output bus bit positions for flags in decoded modes
`define SAF_BIT_INT 8
`define SAF_BIT_ZERO 9
`define SAF_BIT_RVS 10
`define SAF_BIT_SOC 11
// Width of the character carried through the FIFO
`define SAF_CHAR_W 14

`endif

// *** common/saf_pkg.sv ***
/*
 * Types of the receive serial address filter.
 * Assumes saf_defines.svh is visible to the including files.
 */
package saf_pkg;

    // One received character with its flags
    typedef struct packed {
        logic soc;
        logic violation;
        logic special;
        logic [10:0] data;
    } saf_char_t;

    // Static configuration pins
    typedef struct packed {
        logic timing_model;
        logic fifo_bypass_n;
        logic decoder_bypass_n;
        logic char_width;
        logic [1:0] policy;
    } saf_cfg_t;

    // Gate state
    typedef enum logic [1:0] {
        SAF_OPEN,
        SAF_BLOCKED,
        SAF_PASS_ALL
    } saf_gate_t;

endpackage

// *** verilog/saf_sync.sv ***
/*
 * Three-stage synchroniser for a pin level; output changes once the second
 * and third stages agree. Assumes a single clock domain on CLK_I.
 */
`timescale 1ns/10ps

module saf_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Level in and filtered level out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    // Stage chain; s1 is read by s2 only
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Take the level only when the later stages agree, filtering glitches
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q_o[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule

// *** verilog/saf_fifo.sv ***
/*
 * Synchronous FIFO with valid/ready on both sides and honest full/empty.
 * Assumes one clock; read data is an unregistered read of storage at the read pointer.
 */
`timescale 1ns/10ps

module saf_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    // Status
    output logic full_o,
    output logic empty_o
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign full_o = (count_reg == (AW+1)'(DEPTH));
    assign empty_o = (count_reg == '0);
    assign in_ready_o = !full_o;
    assign out_valid_o = !empty_o;
    assign out_data_o = mem[rd_ptr_reg];
    assign push = in_valid_i && !full_o;
    assign pop = out_ready_i && !empty_o;

    // Storage has no reset; only pointers matter
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Occupancy never exceeds depth
    fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        count_reg <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");

endmodule

// *** verilog/saf_filter.sv ***
/*
 * Receive serial address filter with register access over the receive bus,
 * a 32-word receive FIFO and output bus mapping. Assumes an upstream decoder
 * delivers one character per cycle with address and fill flags, on CLK_I.
 */
`timescale 1ns/10ps
`include "saf_defines.svh"

module saf_filter
    import saf_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Reset pair pins, both low restores the address
    input wire logic [1:0] RESET_PAIR_N_I,
    // Configuration pins
    input wire logic FIFO_TIMING_MODEL_SELECT_I,
    input wire logic FIFO_BYPASS_N_I,
    input wire logic DECODER_BYPASS_N_I,
    input wire logic CHAR_WIDTH_SELECT_I,
    input wire logic [1:0] DISCARD_POLICY_SELECT_I,
    // Host control pins
    input wire logic DEVICE_SELECT_N_I,
    input wire logic READ_ENABLE_N_I,
    input wire logic RECEIVER_CLEAR_N_I,
    input wire logic RX_CODE_VIOLATION_I,
    input wire logic SPECIAL_OR_DATA_FLAG_I,
    // Receive parallel bus, three signals for the two-way pins
    input wire logic [11:0] RECEIVE_PARALLEL_BUS_I,
    output logic [11:0] RECEIVE_PARALLEL_BUS_O,
    output logic RECEIVE_PARALLEL_BUS_OE_N_O,
    // Decoded character stream in
    input wire logic CHAR_VALID_I,
    input wire logic [`SAF_CHAR_W-1:0] CHAR_DATA_I,
    input wire logic CHAR_IS_ADDR_I,
    input wire logic CHAR_IS_FILL_I,
    input wire logic REMOTE_INT_I,
    output logic CHAR_READY_O,
    // Status
    output logic UNICAST_MODE_O,
    output logic FILTER_BLOCKING_O,
    output logic FIFO_EMPTY_N_O
);

    logic [9:0] addr_reg;
    logic unicast_reg;
    logic sel_reg;
    logic ren_reg;
    logic clr_reg;
    logic dir_reg;
    logic mode_reg;
    logic [11:0] bus_in_reg;
    logic [1:0] rstpair;
    logic rstpair_prev_reg;
    logic rstpair_hit;
    logic [9:0] all_ones;
    logic [9:0] char_mask;
    logic active;
    logic reg_access;
    logic addr_char;
    logic match;
    logic multi_match;
    logic uni_match;
    logic accept_all;
    saf_gate_t gate_reg;
    saf_gate_t gate_next;
    saf_char_t in_char;
    saf_char_t out_char;
    logic push_valid;
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop;
    logic [`SAF_CHAR_W-1:0] fifo_data;
    logic fifo_empty;

    // Reset pair pins come from outside the clock domain
    saf_sync #(.WIDTH(2)) u_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .d_i(RESET_PAIR_N_I),
        .q_o(rstpair)
    );

    // sample host controls on the rising edge
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sel_reg <= 1'b1;
            ren_reg <= 1'b1;
            clr_reg <= 1'b1;
            dir_reg <= 1'b0;
            mode_reg <= 1'b0;
            bus_in_reg <= 12'h000;
        end else begin
            sel_reg <= DEVICE_SELECT_N_I;
            ren_reg <= READ_ENABLE_N_I;
            clr_reg <= RECEIVER_CLEAR_N_I;
            dir_reg <= RX_CODE_VIOLATION_I;
            mode_reg <= SPECIAL_OR_DATA_FLAG_I;
            bus_in_reg <= RECEIVE_PARALLEL_BUS_I;
        end
    end

    // Detect the falling edge of the pair assertion, a low held for two clocks is enough
    // Starts high: the synchroniser resets low, which must not read as a pulse
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rstpair_prev_reg <= 1'b1;
        end else begin
            rstpair_prev_reg <= (rstpair == 2'b00);
        end
    end
    assign rstpair_hit = (rstpair == 2'b00) && !rstpair_prev_reg;

    // width follows the character width select
    assign all_ones = CHAR_WIDTH_SELECT_I ? `SAF_ADDR_RESET_8 : `SAF_ADDR_RESET_10;
    assign char_mask = all_ones;

    // access needs select, clear and read enable all low
    assign reg_access = !sel_reg && !clr_reg && !ren_reg;

    // register write loads the bus value; power-up and pair reset load accept-all
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            addr_reg <= `SAF_ADDR_RESET_10;
            unicast_reg <= 1'b0;
        end else if (rstpair_hit) begin
            addr_reg <= all_ones;
            unicast_reg <= 1'b0;
        end else if (reg_access && dir_reg == `SAF_DIR_WRITE) begin
            // LSB on bus bit 0, MSB on bit 9 or 7
            addr_reg <= bus_in_reg[9:0] & char_mask;
            unicast_reg <= (mode_reg == `SAF_MODE_UNICAST);
        end
    end

    // filter active only in the low timing model, FIFO on, policy set
    assign active = !FIFO_TIMING_MODEL_SELECT_I && FIFO_BYPASS_N_I &&
                    (DISCARD_POLICY_SELECT_I != `SAF_POLICY_KEEP);

    assign multi_match = |(CHAR_DATA_I[9:0] & addr_reg & char_mask);
    // exact compare over the character width
    assign uni_match = ((CHAR_DATA_I[9:0] & char_mask) == (addr_reg & char_mask));
    assign match = unicast_reg ? uni_match : multi_match;
    assign accept_all = !unicast_reg && ((addr_reg & char_mask) == all_ones);
    assign addr_char = CHAR_VALID_I && CHAR_IS_ADDR_I;

    // gate opens on a match, closes on a mismatch
    always_comb begin
        gate_next = gate_reg;
        case (gate_reg)
            SAF_PASS_ALL: begin
                if (!accept_all && addr_char && !match) begin
                    gate_next = SAF_BLOCKED;
                end
            end
            SAF_OPEN: begin
                if (accept_all) begin
                    gate_next = SAF_PASS_ALL;
                end else if (addr_char && !match) begin
                    gate_next = SAF_BLOCKED;
                end
            end
            SAF_BLOCKED: begin
                if (accept_all) begin
                    gate_next = SAF_PASS_ALL;
                end else if (addr_char && match) begin
                    gate_next = SAF_OPEN;
                end
            end
            default: begin
                gate_next = SAF_PASS_ALL;
            end
        endcase
    end

    // Gate state; follows every consumed character, stalls only on a blocked write
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            gate_reg <= SAF_PASS_ALL;
        end else if (fifo_ready || !push_valid) begin
            gate_reg <= gate_next;
        end
    end

    // write matching address and following data; policy 3 drops
    // the address, policies 2 and 3 drop fill characters
    always_comb begin
        push_valid = CHAR_VALID_I;
        if (active) begin
            if (DISCARD_POLICY_SELECT_I[1] && CHAR_IS_FILL_I) begin
                push_valid = 1'b0;
            end else if (addr_char) begin
                push_valid = (accept_all || match) &&
                             (DISCARD_POLICY_SELECT_I != `SAF_POLICY_DROP_ADDR);
            end else if (gate_reg == SAF_BLOCKED && !accept_all) begin
                push_valid = 1'b0;
            end
        end
    end

    // Back-pressure reaches the decoder only when a write is pending
    assign CHAR_READY_O = fifo_ready || !push_valid;
    assign in_char = CHAR_DATA_I;

    saf_fifo #(.WIDTH(`SAF_CHAR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(in_char),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data),
        .full_o(),
        .empty_o(fifo_empty)
    );

    // FIFO read when selected with read enable and clear released
    assign fifo_pop = !sel_reg && !ren_reg && clr_reg && fifo_valid;
    assign out_char = fifo_data;

    // output mapping; undecoded data passes with bit 0 first in
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RECEIVE_PARALLEL_BUS_O <= 12'h000;
            RECEIVE_PARALLEL_BUS_OE_N_O <= 1'b1;
        end else begin
            RECEIVE_PARALLEL_BUS_OE_N_O <= !(fifo_pop || (reg_access && dir_reg != `SAF_DIR_WRITE));
            if (reg_access) begin
                RECEIVE_PARALLEL_BUS_O <= {2'h0, addr_reg & char_mask};
            end else if (!DECODER_BYPASS_N_I) begin
                RECEIVE_PARALLEL_BUS_O <= CHAR_WIDTH_SELECT_I ? {2'h0, out_char.data[9:0]}
                                                             : {out_char.soc, out_char.data};
            end else begin
                RECEIVE_PARALLEL_BUS_O <= {2'h0, out_char.data[9:0] & char_mask};
                RECEIVE_PARALLEL_BUS_O[`SAF_BIT_RVS] <= out_char.violation;
                RECEIVE_PARALLEL_BUS_O[`SAF_BIT_SOC] <= out_char.soc;
                if (CHAR_WIDTH_SELECT_I) begin
                    RECEIVE_PARALLEL_BUS_O[`SAF_BIT_ZERO] <= 1'b0;
                    RECEIVE_PARALLEL_BUS_O[`SAF_BIT_INT] <= FIFO_BYPASS_N_I ? REMOTE_INT_I
                                                                           : out_char.data[8];
                end
            end
        end
    end

    // Status outputs registered
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            UNICAST_MODE_O <= 1'b0;
            FILTER_BLOCKING_O <= 1'b0;
            FIFO_EMPTY_N_O <= 1'b0;
        end else begin
            UNICAST_MODE_O <= unicast_reg;
            FILTER_BLOCKING_O <= active && (gate_reg == SAF_BLOCKED);
            FIFO_EMPTY_N_O <= !fifo_empty;
        end
    end

    filter_off_pass_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!active && CHAR_VALID_I) |-> push_valid)
        else $error("char dropped while filter inactive");
    timing_model_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        FIFO_TIMING_MODEL_SELECT_I |-> !active)
        else $error("filter active in cascade timing");
    mismatch_blocks_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (active && addr_char && !match && !accept_all && fifo_ready) |=> gate_reg == SAF_BLOCKED)
        else $error("mismatch did not block");
    match_opens_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (addr_char && match && fifo_ready) |=> gate_reg != SAF_BLOCKED)
        else $error("match did not open gate");
    policy3_drop_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (active && addr_char && DISCARD_POLICY_SELECT_I == 2'h3) |-> !push_valid)
        else $error("address written under policy 3");
    accept_all_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (accept_all && CHAR_VALID_I && !CHAR_IS_ADDR_I && !CHAR_IS_FILL_I) |-> push_valid)
        else $error("accept-all dropped data");
    pair_restore_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        rstpair_hit |=> (addr_reg == $past(all_ones) && !unicast_reg))
        else $error("reset pair did not restore");
    write_mode_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (reg_access && !dir_reg && !rstpair_hit) |=> unicast_reg == $past(mode_reg))
        else $error("write mode not taken");
    unicast_exact_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (unicast_reg && match) |-> ((CHAR_DATA_I[9:0] ^ addr_reg) & char_mask) == 10'h000)
        else $error("unicast inexact match");

    cov_block_c: cover property (@(posedge CLK_I) disable iff (!RST_N_I) gate_reg == SAF_BLOCKED);
    cov_write_c: cover property (@(posedge CLK_I) disable iff (!RST_N_I) reg_access && !dir_reg);
    cov_reopen_c: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        gate_reg == SAF_BLOCKED ##1 gate_reg == SAF_OPEN);

endmodule

// *** verif/saf_host_model.sv ***
/*
 * Host bus controller model: register writes, register and FIFO reads.
 * Assumes one task at a time, called 1 ns after a rising edge.
 */
`timescale 1ns/10ps
`include "saf_defines.svh"

module saf_host_model (
    // Clock
    input wire logic clk_i,
    // Device side of the two-way bus
    input wire logic [11:0] dev_bus_i,
    input wire logic dev_oe_n_i,
    // Host pins and resolved bus level
    output logic sel_n_o,
    output logic ren_n_o,
    output logic clr_n_o,
    output logic dir_o,
    output logic mode_o,
    output logic [11:0] wire_o
);
    logic drv = 1'b0;
    logic [11:0] hd = 12'h5a5;
    logic [11:0] rdata;
    event took;

    // Idle pins until the first access
    initial begin
        {sel_n_o, ren_n_o, clr_n_o, dir_o, mode_o} = 5'h1c;
    end

    // Released bus toggles, so a stale value never reads as good
    always @(posedge clk_i) begin
        if (!drv) begin
            hd <= ~hd;
        end
    end
    assign wire_o = dev_oe_n_i ? hd : dev_bus_i;

    task automatic write_reg(input logic mode, input logic [9:0] val);
        @(posedge clk_i);
        #1;
        {sel_n_o, ren_n_o, clr_n_o, dir_o, mode_o} = {3'h0, `SAF_DIR_WRITE, mode};
        hd = {2'h0, val};
        drv = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        drv = 1'b0;
        {sel_n_o, ren_n_o, clr_n_o} = 3'h7;
    endtask

    // read access
    // One sampled cycle only: each held cycle would pop another FIFO word
    task automatic read(input logic clr_n, input logic mode);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        {sel_n_o, ren_n_o, clr_n_o, dir_o, mode_o} = {2'h0, clr_n, ~`SAF_DIR_WRITE, mode};
        @(posedge clk_i);
        #1;
        {sel_n_o, ren_n_o, clr_n_o} = 3'h7;
        do begin
            @(posedge clk_i);
            n++;
        end while (dev_oe_n_i !== 1'b0 && n < 8);
        rdata = (n < 8) ? wire_o : 12'hxxx;
        -> took;
        #1;
    endtask
endmodule

// *** verif/tb.sv ***
/*
 * Self-checking bench for the receive serial address filter.
 * Assumes saf_host_model plays the host; the bench plays the decoder.
 */
`timescale 1ns/10ps

module tb import saf_pkg::*;;
    typedef struct {
        bit reg_kind;
        logic [11:0] v;
    } saf_note_t;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] pair_n = 2'h3;
    saf_cfg_t cfg = '{1'b0, 1'b1, 1'b1, 1'b0, 2'h2};
    saf_char_t ch = '0;
    logic valid = 1'b0;
    logic is_addr = 1'b0;
    logic is_fill = 1'b0;
    logic rint = 1'b0;
    logic ready, oe_n, sel_n, ren_n, clr_n, dir, mode, uni, blk, nempty;
    logic [11:0] dev_bus, bus;
    logic [11:0] mq[$];
    saf_note_t sq[$];
    saf_note_t nt;
    int n_errors = 0;
    int compares = 0;

    // 25 MHz clock
    initial begin
        forever #20 clk = ~clk;
    end

    saf_filter #(.FIFO_DEPTH(32)) u_saf_filter (
        .CLK_I(clk), .RST_N_I(rst_n), .RESET_PAIR_N_I(pair_n),
        .FIFO_TIMING_MODEL_SELECT_I(cfg.timing_model), .FIFO_BYPASS_N_I(cfg.fifo_bypass_n),
        .DECODER_BYPASS_N_I(cfg.decoder_bypass_n), .CHAR_WIDTH_SELECT_I(cfg.char_width),
        .DISCARD_POLICY_SELECT_I(cfg.policy), .DEVICE_SELECT_N_I(sel_n), .READ_ENABLE_N_I(ren_n),
        .RECEIVER_CLEAR_N_I(clr_n), .RX_CODE_VIOLATION_I(dir), .SPECIAL_OR_DATA_FLAG_I(mode),
        .RECEIVE_PARALLEL_BUS_I(bus), .RECEIVE_PARALLEL_BUS_O(dev_bus),
        .RECEIVE_PARALLEL_BUS_OE_N_O(oe_n), .CHAR_VALID_I(valid), .CHAR_DATA_I(ch),
        .CHAR_IS_ADDR_I(is_addr), .CHAR_IS_FILL_I(is_fill), .REMOTE_INT_I(rint),
        .CHAR_READY_O(ready), .UNICAST_MODE_O(uni), .FILTER_BLOCKING_O(blk), .FIFO_EMPTY_N_O(nempty));

    saf_host_model u_saf_host_model (
        .clk_i(clk), .dev_bus_i(dev_bus), .dev_oe_n_i(oe_n), .sel_n_o(sel_n), .ren_n_o(ren_n),
        .clr_n_o(clr_n), .dir_o(dir), .mode_o(mode), .wire_o(bus));

    task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_word({11'h0, got}, {11'h0, exp});
    endtask

    function automatic logic [11:0] fmt(saf_char_t c);
        if (!cfg.decoder_bypass_n) begin
            return {c.soc, c.data};
        end
        if (cfg.char_width) begin
            return {c.soc, c.violation, 1'b0, rint, c.data[7:0]};
        end
        return {c.soc, c.violation, c.data[9:0]};
    endfunction

    // Hand one character over; valid stays up so sends run back to back
    task automatic send(input logic [13:0] c, input logic a, input logic f, input logic keep);
        int n;
        n = 0;
        valid = 1'b1;
        ch = c;
        is_addr = a;
        is_fill = f;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        if (keep) mq.push_back(fmt(c));
        #1;
    endtask

    task automatic quiet();
        valid = 1'b0;
    endtask

    task automatic reg_read(input logic m, input logic [9:0] exp);
        sq.push_back('{1'b1, {2'h0, exp}});
        u_saf_host_model.read(1'b0, m);
    endtask

    task automatic drain();
        while (mq.size() > 0) begin
            sq.push_back('{1'b0, mq.pop_front()});
            u_saf_host_model.read(1'b1, 1'b0);
        end
        cmp_flag(nempty, 1'b0);
    endtask

    task automatic complete_run();
        $display("compares=%0d mismatches=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Every word the host takes is matched against the oldest note
    initial begin
        forever begin
            @(u_saf_host_model.took);
            nt = sq.pop_front();
            cmp_word(u_saf_host_model.rdata & (nt.reg_kind ? 12'h3ff : 12'hfff), nt.v);
        end
    end

    // Hang guard, far past the few hundred cycles the tests need
    initial begin
        #(20000 * 40);
        n_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h3823));
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        // Accept-all after reset, fill dropped under policy 2
        reg_read(1'b0, 10'h3ff);
        cmp_flag(uni, 1'b0);
        send(14'h2f0, 1'b1, 1'b0, 1'b1);
        send(14'h155, 1'b0, 1'b0, 1'b1);
        send(14'h0bc, 1'b0, 1'b1, 1'b0);
        quiet();
        cmp_flag(nempty, 1'b1);
        drain();
        $display("test accept_all done");
        // Multicast domains under policies 1 to 3
        u_saf_host_model.write_reg(1'b0, 10'h005);
        reg_read(1'b0, 10'h005);
        for (int p = 1; p < 4; p++) begin
            cfg.policy = 2'(p);
            send(14'h002, 1'b1, 1'b0, 1'b0);
            send(14'h011, 1'b0, 1'b0, 1'b0);
            quiet();
            cmp_flag(blk, 1'b1);
            send(14'h104, 1'b1, 1'b0, p != 3);
            send(14'h3a7, 1'b0, 1'b0, 1'b1);
            send(14'h0bc, 1'b0, 1'b1, p == 1);
            quiet();
            cmp_flag(blk, 1'b0);
            drain();
        end
        $display("test multicast done");
        // Unicast exact match
        cfg.policy = 2'h2;
        u_saf_host_model.write_reg(1'b1, 10'h2a5);
        reg_read(1'b1, 10'h2a5);
        cmp_flag(uni, 1'b1);
        send(14'h2a4, 1'b1, 1'b0, 1'b0);
        send(14'h0aa, 1'b0, 1'b0, 1'b0);
        send(14'h2a5, 1'b1, 1'b0, 1'b1);
        send(14'h1c3, 1'b0, 1'b0, 1'b1);
        quiet();
        drain();
        $display("test unicast done");
        // Policy 0 and the cascade model leave the register without effect
        cfg.policy = 2'h0;
        send(14'h000, 1'b1, 1'b0, 1'b1);
        send(14'h0c3, 1'b0, 1'b0, 1'b1);
        quiet();
        cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 2'h2};
        send(14'h001, 1'b1, 1'b0, 1'b1);
        send(14'h03c, 1'b0, 1'b0, 1'b1);
        quiet();
        cfg.timing_model = 1'b0;
        drain();
        $display("test filter_off done");
        // Reset pair restores accept-all multicast
        pair_n = 2'h0;
        repeat (6) @(posedge clk);
        #1;
        pair_n = 2'h3;
        repeat (6) @(posedge clk);
        reg_read(1'b0, 10'h3ff);
        cmp_flag(uni, 1'b0);
        $display("test reset_pair done");
        // Output mappings with random characters
        cfg.char_width = 1'b1;
        rint = 1'b1;
        u_saf_host_model.write_reg(1'b0, 10'h3ff);
        reg_read(1'b0, 10'h0ff);
        repeat (4) send(14'($urandom()), 1'b0, 1'b0, 1'b1);
        quiet();
        drain();
        cfg.decoder_bypass_n = 1'b0;
        cfg.char_width = 1'b0;
        u_saf_host_model.write_reg(1'b0, 10'h3ff);
        repeat (4) send(14'($urandom()), 1'b0, 1'b0, 1'b1);
        quiet();
        drain();
        $display("test mapping done");
        // Fill the FIFO until it refuses, then drain it
        cfg.decoder_bypass_n = 1'b1;
        repeat (32) send(14'($urandom()), 1'b0, 1'b0, 1'b1);
        ch = 14'h1ff;
        @(posedge clk);
        cmp_flag(ready, 1'b0);
        #1;
        quiet();
        drain();
        $display("test fifo_full done");
        complete_run();
    end
endmodule
